// file: src/port_phy_control_status_reg.sv
// Purpose: per-port transceiver control/status bytes and partner bit
// Assumes: status inputs come from logic on clk, no synchronising
// Notes:   reads answer one cycle after the strobe
`timescale 1ns/1ps

module port_phy_control_status_reg (
    // clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    // register port
    input  wire logic [7:0]                            regAddr,
    input  wire logic                                  regWrite,
    input  wire logic                                  regRead,
    input  wire logic [port_ctrl_pkg::DATA_W-1:0]      regWriteData,
    output logic      [port_ctrl_pkg::DATA_W-1:0]      regReadData,
    output logic                                       regReadValid,
    // management view
    input  wire logic [port_ctrl_pkg::PORT_IDX_W-1:0]  miimPort,
    input  wire logic                                  miimRead,
    output logic      [port_ctrl_pkg::DATA_W-1:0]      miimReadData,
    output logic                                       miimReadValid,
    // transceiver status
    input  wire logic [port_ctrl_pkg::NUM_PORTS-1:0]   anBusy,
    input  wire logic [port_ctrl_pkg::NUM_PORTS-1:0]   speed100,
    input  wire logic [port_ctrl_pkg::NUM_PORTS-1:0]   fullDuplex,
    input  wire logic [port_ctrl_pkg::NUM_PORTS-1:0]   partnerTenHalf,
    // transceiver control
    output logic      [port_ctrl_pkg::NUM_PORTS-1:0]   lineSideLoopback,
    output logic      [port_ctrl_pkg::NUM_PORTS-1:0]   transceiverIsolation,
    output logic      [port_ctrl_pkg::NUM_PORTS-1:0]   softReset,
    output logic      [port_ctrl_pkg::NUM_PORTS-1:0]   forceLink
);
    import port_ctrl_pkg::*;

    logic [MODE_W-1:0]    modeField   [NUM_PORTS];
    logic [MODE_W-1:0]    next_modeField [NUM_PORTS];
    logic [NUM_PORTS-1:0] partnerStat;
    logic [NUM_PORTS-1:0] next_partnerStat;
    logic [NUM_PORTS-1:0] next_loopback;
    logic [NUM_PORTS-1:0] next_isolation;
    logic [NUM_PORTS-1:0] next_softReset;
    logic [NUM_PORTS-1:0] next_forceLink;
    logic [DATA_W-1:0]    ctrlView    [NUM_PORTS];
    logic [NUM_PORTS-1:0] ctrlHit;
    logic [NUM_PORTS-1:0] statHit;
    logic [DATA_W-1:0]    next_regReadData;
    logic                 next_regReadValid;
    logic [DATA_W-1:0]    next_miimReadData;
    logic                 next_miimReadValid;

    // address decode and readable byte per port
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            ctrlHit[p] = (regAddr == CTRL_OFS[p]);
            statHit[p] = (regAddr == STAT_OFS[p]);
            ctrlView[p] = {lineSideLoopback[p],
                           RESERVED_VAL,
                           transceiverIsolation[p],
                           softReset[p],
                           forceLink[p],
                           modeField[p]};
        end
    end

    // hardware-owned status: follows the transceiver, never the bus
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_partnerStat[p] = partnerTenHalf[p];
            if (anBusy[p]) begin
                next_modeField[p] = MODE_AN_BUSY;
            end else begin
                case ({speed100[p], fullDuplex[p]})
                    2'b00:   next_modeField[p] = MODE_10_HALF;
                    2'b10:   next_modeField[p] = MODE_100_HALF;
                    2'b01:   next_modeField[p] = MODE_10_FULL;
                    2'b11:   next_modeField[p] = MODE_100_FULL;
                    default: next_modeField[p] = MODE_AN_BUSY;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            partnerStat <= {NUM_PORTS{PARTNER_RESET}};
            for (int p = 0; p < NUM_PORTS; p++) begin
                modeField[p] <= MODE_RESET;
            end
        end else begin
            partnerStat <= next_partnerStat;
            for (int p = 0; p < NUM_PORTS; p++) begin
                modeField[p] <= next_modeField[p];
            end
        end
    end

    // software-owned control bits
    always_comb begin
        next_loopback  = lineSideLoopback;
        next_isolation = transceiverIsolation;
        next_forceLink = forceLink;
        // soft reset lives for one cycle only, so reads see 0 after
        next_softReset = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (regWrite && ctrlHit[p]) begin
                next_loopback[p]  = regWriteData[BIT_LOOPBACK];
                next_isolation[p] = regWriteData[BIT_ISOLATE];
                next_softReset[p] = regWriteData[BIT_SOFT_RESET];
                next_forceLink[p] = regWriteData[BIT_FORCE_LINK];
                // bits 6 and 2:0 dropped here
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lineSideLoopback     <= {NUM_PORTS{CTRL_RESET}};
            transceiverIsolation <= {NUM_PORTS{CTRL_RESET}};
            softReset            <= {NUM_PORTS{CTRL_RESET}};
            forceLink            <= {NUM_PORTS{CTRL_RESET}};
        end else begin
            lineSideLoopback     <= next_loopback;
            transceiverIsolation <= next_isolation;
            softReset            <= next_softReset;
            forceLink            <= next_forceLink;
        end
    end

    // read answers; unmapped addresses return zero
    always_comb begin
        next_regReadValid  = regRead;
        next_regReadData   = regReadData;
        if (regRead) begin
            next_regReadData = READ_RESET;
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (ctrlHit[p]) begin
                    next_regReadData = ctrlView[p];
                end
                if (statHit[p]) begin
                    next_regReadData[BIT_PARTNER_10H] =
                        partnerStat[p];
                end
            end
        end
        next_miimReadValid = miimRead;
        next_miimReadData  = miimReadData;
        if (miimRead) begin
            next_miimReadData = READ_RESET;
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (miimPort == PORT_IDX_W'(p)) begin
                    next_miimReadData = ctrlView[p];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regReadData   <= READ_RESET;
            regReadValid  <= 1'b0;
            miimReadData  <= READ_RESET;
            miimReadValid <= 1'b0;
        end else begin
            regReadData   <= next_regReadData;
            regReadValid  <= next_regReadValid;
            miimReadData  <= next_miimReadData;
            miimReadValid <= next_miimReadValid;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_PARTNER_READ: assert property (
        regRead && statHit[0] |=> regReadValid
            && regReadData == {7'h00, $past(partnerStat[0])})
        else $error("status bit 0 read does not show partner ability");

    AST_PORT5_DECODE: assert property (
        regRead && regAddr == CTRL_OFS[4]
            |=> regReadData == $past(ctrlView[4]))
        else $error("port 5 register not decoded at its offset");

    AST_LOOPBACK_SET: assert property (
        regWrite && ctrlHit[0]
            |=> lineSideLoopback[0] == $past(regWriteData[BIT_LOOPBACK]))
        else $error("loopback control not taken from write");

    AST_RESERVED_ZERO: assert property (
        regRead |=> !regReadData[BIT_RESERVED])
        else $error("reserved bit 6 read as one");

    AST_ISOLATE_HOLD: assert property (
        !(regWrite && ctrlHit[0]) |=> $stable(transceiverIsolation[0]))
        else $error("isolation changed without a write");

    AST_SOFT_RESET_CLEAR: assert property (
        regWrite && ctrlHit[1] && regWriteData[BIT_SOFT_RESET]
            |=> softReset[1] ##1 (!softReset[1]
                || $past(regWrite && ctrlHit[1]
                    && regWriteData[BIT_SOFT_RESET])))
        else $error("soft reset did not pulse and clear");

    AST_FORCE_LINK_SET: assert property (
        regWrite && ctrlHit[2]
            |=> forceLink[2] == $past(regWriteData[BIT_FORCE_LINK]))
        else $error("force link not taken from write");

    AST_MODE_100_FULL: assert property (
        !anBusy[0] && speed100[0] && fullDuplex[0]
            |=> modeField[0] == MODE_100_FULL)
        else $error("mode field wrong for 100 full");

    AST_MODE_10_HALF: assert property (
        !anBusy[3] && !speed100[3] && !fullDuplex[3]
            |=> modeField[3] == MODE_10_HALF)
        else $error("mode field wrong for 10 half");

    AST_MODE_NEGOTIATING: assert property (
        anBusy[0] [*2] |-> modeField[0] == MODE_AN_BUSY)
        else $error("mode field not 001 while negotiating");

    AST_MIIM_MATCH: assert property (
        miimRead && miimPort == 3'h0
            |=> miimReadValid && miimReadData == $past(ctrlView[0]))
        else $error("management read differs from register");

    AST_RO_IGNORED: assert property (
        regWrite && ctrlHit[0] && anBusy[0]
            |=> modeField[0] == MODE_AN_BUSY)
        else $error("write altered read-only mode field");

    AST_STATUS_UPPER_ZERO: assert property (
        regRead && (|statHit) |=> regReadData[DATA_W-1:1] == '0)
        else $error("status register upper bits not zero");

    AST_UNMAPPED_ZERO: assert property (
        regRead && !(|ctrlHit) && !(|statHit)
            |=> regReadData == READ_RESET)
        else $error("unmapped read returned nonzero data");

    AST_READ_VALID: assert property (
        regReadValid == $past(regRead))
        else $error("read valid not one cycle after strobe");

    AST_LOOPBACK_HOLD: assert property (
        !(regWrite && ctrlHit[2]) |=> $stable(lineSideLoopback[2]))
        else $error("loopback changed without a write");

    AST_ISOLATE_SET: assert property (
        regWrite && ctrlHit[3]
            |=> transceiverIsolation[3] == $past(regWriteData[BIT_ISOLATE]))
        else $error("isolation control not taken from write");

    AST_SOFT_RESET_IDLE: assert property (
        !(regWrite && ctrlHit[4] && regWriteData[BIT_SOFT_RESET])
            |=> !softReset[4])
        else $error("soft reset pulsed without a write");

    AST_FORCE_LINK_HOLD: assert property (
        !(regWrite && ctrlHit[1]) |=> $stable(forceLink[1]))
        else $error("force link changed without a write");

    AST_MODE_100_HALF: assert property (
        !anBusy[4] && speed100[4] && !fullDuplex[4]
            |=> modeField[4] == MODE_100_HALF)
        else $error("mode field wrong for 100 half");

    AST_MODE_10_FULL: assert property (
        !anBusy[2] && !speed100[2] && fullDuplex[2]
            |=> modeField[2] == MODE_10_FULL)
        else $error("mode field wrong for 10 full");

    AST_MIIM_UNMAPPED: assert property (
        miimRead && miimPort >= PORT_IDX_W'(NUM_PORTS)
            |=> miimReadData == READ_RESET)
        else $error("management read of unknown port not zero");

    AST_STATUS_WRITE_IGNORED: assert property (
        regWrite && statHit[0]
            |=> partnerStat[0] == $past(partnerTenHalf[0]))
        else $error("write altered read-only partner bit");

    COV_SOFT_RESET: cover property (
        regWrite && ctrlHit[0] && regWriteData[BIT_SOFT_RESET]
            ##1 softReset[0]);
    COV_AN_DONE: cover property (
        modeField[2] == MODE_AN_BUSY ##1 modeField[2] == MODE_10_FULL);
    COV_MIIM_PORT5: cover property (
        miimRead && miimPort == 3'h4 ##1 miimReadValid);
    COV_UNMAPPED_READ: cover property (
        regRead && !(|ctrlHit) && !(|statHit) ##1 regReadValid);
    COV_MODE_100_FULL: cover property (
        modeField[0] == MODE_100_FULL);
endmodule : port_phy_control_status_reg

// file: include/port_ctrl_pkg.sv
// Purpose: constants for the per-port transceiver control/status bank
// Assumes: five ports, 8-bit registers, one switch clock
// Notes:   offsets are byte addresses on the register port
package port_ctrl_pkg;
    localparam int NUM_PORTS = 5;
    localparam int DATA_W    = 8;
    localparam int MODE_W    = 3;
    localparam int PORT_IDX_W = 3;

    // combined control/status byte, ports 1..5
    localparam logic [7:0] CTRL_OFS [NUM_PORTS] =
        '{8'h1F, 8'h2F, 8'h3F, 8'h4F, 8'h5F};
    // preceding partner status bytes, only bit 0 lives here
    localparam logic [7:0] STAT_OFS [NUM_PORTS] =
        '{8'h1E, 8'h2E, 8'h3E, 8'h4E, 8'h5E};

    // control byte field positions, plus the status byte partner bit
    localparam int BIT_LOOPBACK   = 7;
    localparam int BIT_RESERVED   = 6;
    localparam int BIT_ISOLATE    = 5;
    localparam int BIT_SOFT_RESET = 4;
    localparam int BIT_FORCE_LINK = 3;
    localparam int BIT_PARTNER_10H = 0;

    // operating mode codes
    localparam logic [MODE_W-1:0] MODE_AN_BUSY  = 3'h1;
    localparam logic [MODE_W-1:0] MODE_10_HALF  = 3'h2;
    localparam logic [MODE_W-1:0] MODE_100_HALF = 3'h3;
    localparam logic [MODE_W-1:0] MODE_10_FULL  = 3'h5;
    localparam logic [MODE_W-1:0] MODE_100_FULL = 3'h6;

    // reset values
    localparam logic              CTRL_RESET    = 1'b0;
    localparam logic              PARTNER_RESET = 1'b0;
    localparam logic [MODE_W-1:0] MODE_RESET    = MODE_AN_BUSY;
    localparam logic [DATA_W-1:0] READ_RESET    = 8'h00;
    localparam logic              RESERVED_VAL  = 1'b0;
endpackage : port_ctrl_pkg

// file: bench/mgmt_master.sv
// Purpose: management controller model on the read-only view
// Assumes: bench raises go for one cycle per read
// Notes:   idle index toggles so a stale index never reads back
`timescale 1ns/1ps
module mgmt_master (
    // clock
    input  wire logic                                 clk,
    // request from the bench
    input  wire logic                                 go,
    input  wire logic [port_ctrl_pkg::PORT_IDX_W-1:0] goPort,
    // management read port
    output logic                                      miimRead,
    output logic      [port_ctrl_pkg::PORT_IDX_W-1:0] miimPort
);
    import port_ctrl_pkg::*;
    initial begin
        miimRead = 1'b0;
        miimPort = 3'h0;
    end
    always @(posedge clk) begin
        miimRead <= go;
        miimPort <= go ? goPort : ~miimPort;
    end
endmodule : mgmt_master

// file: bench/port_phy_control_status_reg_tb_top.sv
// Purpose: self-checking bench for the port control/status bank
// Assumes: one read answer per read strobe, in order
// Notes:   expectations queued by drivers, popped by monitors
`timescale 1ns/1ps
module port_phy_control_status_reg_tb_top;
    import port_ctrl_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, go = 1'b0;
    logic       regWrite = 1'b0, regRead = 1'b0;
    logic [7:0] regAddr = 8'h00, regWriteData = 8'h00;
    logic [2:0] goPort = 3'h0, miimPort;
    logic [4:0] anBusy = 5'h1F, speed100 = 5'h00;
    logic [4:0] fullDuplex = 5'h00, partnerTenHalf = 5'h00;
    logic [4:0] loopOut, isoOut, srOut, forceOut;
    logic [7:0] regReadData, miimReadData, ctl;
    logic       regReadValid, miimRead, miimReadValid;
    logic [7:0] regQ[$], miimQ[$], srQ[$];
    logic [31:0] r;
    int num_errors = 0, check_count = 0, seed = 97, q;
    localparam logic [2:0] MODES [4] =
        '{MODE_10_HALF, MODE_100_HALF, MODE_10_FULL, MODE_100_FULL};
    // fixed order so each mode assertion's port gets its mode
    localparam int PORT_ORDER [4] = '{3, 4, 2, 0};

    always #10 clk = ~clk;

    port_phy_control_status_reg uut (.clk(clk), .rst(rst),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWriteData(regWriteData), .regReadData(regReadData),
        .regReadValid(regReadValid), .miimPort(miimPort),
        .miimRead(miimRead), .miimReadData(miimReadData),
        .miimReadValid(miimReadValid), .anBusy(anBusy),
        .speed100(speed100), .fullDuplex(fullDuplex),
        .partnerTenHalf(partnerTenHalf), .lineSideLoopback(loopOut),
        .transceiverIsolation(isoOut), .softReset(srOut),
        .forceLink(forceOut));
    mgmt_master mgmt (.clk(clk), .go(go), .goPort(goPort),
        .miimRead(miimRead), .miimPort(miimPort));

    task automatic check(string name, logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s exp %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic rd(logic [7:0] a, exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        regQ.push_back(exp);
        @(posedge clk);
        regRead <= 1'b0;
    endtask : rd

    task automatic wr(logic [7:0] a, d, sr);
        @(posedge clk);
        regWrite     <= 1'b1;
        regAddr      <= a;
        regWriteData <= d;
        if (sr != 8'h00) srQ.push_back(sr);
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic mg(logic [2:0] p, logic [7:0] exp);
        @(posedge clk);
        go     <= 1'b1;
        goPort <= p;
        miimQ.push_back(exp);
        @(posedge clk);
        go <= 1'b0;
    endtask : mg

    // an answer with no queued note is itself a mismatch
    always @(posedge clk) begin
        if (regReadValid === 1'b1)
            check("reg", regReadData,
                  regQ.size() ? regQ.pop_front() : ~regReadData);
        if (miimReadValid === 1'b1)
            check("miim", miimReadData,
                  miimQ.size() ? miimQ.pop_front() : ~miimReadData);
        if (srOut !== 5'h00)
            check("sreset", {3'h0, srOut},
                  srQ.size() ? srQ.pop_front() : 8'h00);
    end

    initial begin
        #100us;
        num_errors++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        r = $random(seed);
        for (int p = 0; p < 5; p++) begin
            rd(CTRL_OFS[p], 8'h01);
            rd(STAT_OFS[p], 8'h00);
        end
        partnerTenHalf <= r[4:0];
        for (int p = 0; p < 5; p++) begin
            wr(CTRL_OFS[p], 8'hBF, 8'(1 << p));
            wr(STAT_OFS[p], 8'hFF, 8'h00);
            rd(CTRL_OFS[p], 8'hA9);
            rd(STAT_OFS[p], {7'h00, r[p]});
        end
        check("loop", {3'h0, loopOut}, 8'h1F);
        check("iso", {3'h0, isoOut}, 8'h1F);
        check("force", {3'h0, forceOut}, 8'h1F);
        wr(CTRL_OFS[0], 8'h00, 8'h00);
        wr(8'h30, 8'hFF, 8'h00);
        rd(8'h20, 8'h00);
        rd(CTRL_OFS[0], 8'h01);
        check("loop", {3'h0, loopOut}, 8'h1E);
        for (int i = 0; i < 4; i++) begin
            q = PORT_ORDER[i];
            ctl = (q == 0) ? 8'h00 : 8'hA8;
            anBusy[q]     <= 1'b0;
            speed100[q]   <= i[0];
            fullDuplex[q] <= i[1];
            repeat (2) @(posedge clk);
            rd(CTRL_OFS[q], ctl | {5'h00, MODES[i]});
            mg(3'(q), ctl | {5'h00, MODES[i]});
            anBusy[q] <= 1'b1;
            repeat (2) @(posedge clk);
            rd(CTRL_OFS[q], ctl | 8'h01);
        end
        mg(3'h5, 8'h00);
        repeat (4) @(posedge clk);
        check("left", 8'(regQ.size() + miimQ.size() + srQ.size()),
              8'h00);
        test_done();
    end
endmodule : port_phy_control_status_reg_tb_top
